// [include/wws_pkg.sv]
// Constants, timings and types shared by the window watchdog supervisor
package wws_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and counter sizing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CNT_W = 26;

  ////////////////////////////////////////////////////////////////////////////////
  // Times in ns, counts in core clock cycles (least times round up, longest down)
  localparam int RESET_HOLD_NS = 200_000_000;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_LOW_FLOAT_NS = 800_000_000;
  localparam int WIN_LOW_FLOAT_CYC = (WIN_LOW_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_UP_FLOAT_NS = 1_600_000_000;
  localparam int WIN_UP_FLOAT_CYC = WIN_UP_FLOAT_NS / CLK_PERIOD_NS;
  localparam int WIN_LOW_PULL_NS = 1_850_000;
  localparam int WIN_LOW_PULL_CYC = (WIN_LOW_PULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_UP_PULL_NS = 11_000_000;
  localparam int WIN_UP_PULL_CYC = WIN_UP_PULL_NS / CLK_PERIOD_NS;
  localparam int CFG_EVAL_NS = 381_000;
  localparam int CFG_EVAL_CYC = CFG_EVAL_NS / CLK_PERIOD_NS;
  localparam int CFG_SENSE_NS = 100_000;
  localparam int CFG_SENSE_CYC = CFG_SENSE_NS / CLK_PERIOD_NS;
  localparam int SETTLE_NS = 150_000;
  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RAMP_GUARD_CYC = 26'h0000004;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port map and fields
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = 4'h4;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam int CTRL_WD_OFF_BIT = 0;
  localparam int ST_RST_BIT = 0;
  localparam int ST_FAULT_BIT = 1;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_VALID_BIT = 4;
  localparam int ST_SUPV_BIT = 5;
  localparam int ST_RST_PIN_BIT = 6;
  localparam int ST_WDO_PIN_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised input bit positions
  localparam int SYN_W = 9;
  localparam int SY_BELOW = 0;
  localparam int SY_ABOVE = 1;
  localparam int SY_MR_N = 2;
  localparam int SY_EN = 3;
  localparam int SY_KICK = 4;
  localparam int SY_PULLUP = 5;
  localparam int SY_RAMP = 6;
  localparam int SY_RST_PIN = 7;
  localparam int SY_WDO_PIN = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {CFG_FLOAT, CFG_PULLUP, CFG_CAP} wws_cfg_e;
  typedef enum logic [1:0] {CLS_IDLE, CLS_SENSE, CLS_CHARGE, CLS_DONE} wws_cls_e;
  typedef enum logic [1:0] {RS_ASSERT, RS_HOLD, RS_RELEASED} wws_rst_e;
  typedef enum logic [2:0] {WD_OFF, WD_SETTLE, WD_FIRST, WD_WINDOW, WD_FAULT} wws_wd_e;

endpackage

// [verilog/wws_sync.sv]
// Two-flop synchroniser bank for asynchronous pin inputs
module wws_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] reset_val,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Reset value is applied after the second stage, so the flops keep constants
  assign sync_out = sync_q ^ reset_val;

endmodule

// [verilog/wws_cfg_detect.sv]
// Timing configuration pin classifier: floating, pull-up or capacitor
module wws_cfg_detect #(
  parameter int EVAL_CYC = wws_pkg::CFG_EVAL_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic pullup_sense,
  input wire logic ramp_done,
  output logic charge_req,
  output logic busy,
  output logic valid,
  output wws_pkg::wws_cfg_e mode
);

  localparam logic [wws_pkg::CNT_W-1:0] SENSE_C = wws_pkg::CNT_W'(wws_pkg::CFG_SENSE_CYC);
  localparam logic [wws_pkg::CNT_W-1:0] EVAL_C = wws_pkg::CNT_W'(EVAL_CYC);

  wws_pkg::wws_cls_e state_q, state_d;
  wws_pkg::wws_cfg_e mode_q, mode_d;
  logic [wws_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic valid_q, valid_d;

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    cnt_d = cnt_q + 26'h0000001;
    valid_d = valid_q;
    unique case (state_q)
      wws_pkg::CLS_IDLE: begin
        cnt_d = '0;
      end
      wws_pkg::CLS_SENSE: begin
        // Pin discharged: only a pull-up still reads high
        if (cnt_q >= SENSE_C) begin
          if (pullup_sense) begin
            mode_d = wws_pkg::CFG_PULLUP;
            state_d = wws_pkg::CLS_DONE;
          end else begin
            state_d = wws_pkg::CLS_CHARGE;
          end
        end
      end
      wws_pkg::CLS_CHARGE: begin
        // Open pin trips the ramp almost at once, a capacitor does not
        if (ramp_done) begin
          mode_d = wws_pkg::CFG_FLOAT;
          state_d = wws_pkg::CLS_DONE;
        end else if (cnt_q >= EVAL_C) begin
          mode_d = wws_pkg::CFG_CAP;
          state_d = wws_pkg::CLS_DONE;
        end
      end
      wws_pkg::CLS_DONE: begin
        cnt_d = '0;
        valid_d = 1'b1;
        state_d = wws_pkg::CLS_IDLE;
      end
    endcase
    if (start) begin
      state_d = wws_pkg::CLS_SENSE;
      cnt_d = '0;
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= wws_pkg::CLS_IDLE;
      mode_q <= wws_pkg::CFG_FLOAT;
      cnt_q <= '0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      valid_q <= valid_d;
    end
  end

  assign charge_req = (state_q == wws_pkg::CLS_CHARGE);
  assign busy = (state_q == wws_pkg::CLS_SENSE) || (state_q == wws_pkg::CLS_CHARGE);
  assign valid = valid_q;
  assign mode = mode_q;

endmodule

// [verilog/wws_top.sv]
// Supply supervisor with window watchdog, open-drain reset and fault outputs
module wws_top #(
  parameter int HOLD_CYC = wws_pkg::RESET_HOLD_CYC,
  parameter int LOW_FLOAT_CYC = wws_pkg::WIN_LOW_FLOAT_CYC,
  parameter int UP_FLOAT_CYC = wws_pkg::WIN_UP_FLOAT_CYC,
  parameter int LOW_PULL_CYC = wws_pkg::WIN_LOW_PULL_CYC,
  parameter int UP_PULL_CYC = wws_pkg::WIN_UP_PULL_CYC,
  parameter int EVAL_CYC = wws_pkg::CFG_EVAL_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_below_falling,
  input wire logic supply_above_rising,
  input wire logic manual_reset_input_n,
  input wire logic watchdog_enable_select,
  input wire logic watchdog_kick_input,
  input wire logic cfg_pullup_sense,
  input wire logic cfg_ramp_done,
  output logic cfg_charge_en,
  input wire logic system_reset_n_in,
  output logic system_reset_n_out,
  output logic system_reset_n_oe,
  input wire logic watchdog_fault_output_n_in,
  output logic watchdog_fault_output_n_out,
  output logic watchdog_fault_output_n_oe,
  input wire logic [wws_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  localparam logic [wws_pkg::CNT_W-1:0] HOLD_C = wws_pkg::CNT_W'(HOLD_CYC);
  localparam logic [wws_pkg::CNT_W-1:0] LOW_FLOAT_C = wws_pkg::CNT_W'(LOW_FLOAT_CYC);
  localparam logic [wws_pkg::CNT_W-1:0] UP_FLOAT_C = wws_pkg::CNT_W'(UP_FLOAT_CYC);
  localparam logic [wws_pkg::CNT_W-1:0] LOW_PULL_C = wws_pkg::CNT_W'(LOW_PULL_CYC);
  localparam logic [wws_pkg::CNT_W-1:0] UP_PULL_C = wws_pkg::CNT_W'(UP_PULL_CYC);
  localparam logic [wws_pkg::SYN_W-1:0] SYNC_INV = 9'h004;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [wws_pkg::SYN_W-1:0] pins_raw;
  logic [wws_pkg::SYN_W-1:0] pins_s;
  logic below_s;
  logic above_s;
  logic mr_n_s;
  logic en_s;
  logic kick_s;
  logic ramp_s;

  always_comb begin
    pins_raw = '0;
    pins_raw[wws_pkg::SY_BELOW] = supply_below_falling;
    pins_raw[wws_pkg::SY_ABOVE] = supply_above_rising;
    // Inverted through the bank so the synced level idles high out of reset
    pins_raw[wws_pkg::SY_MR_N] = ~manual_reset_input_n;
    pins_raw[wws_pkg::SY_EN] = watchdog_enable_select;
    pins_raw[wws_pkg::SY_KICK] = watchdog_kick_input;
    pins_raw[wws_pkg::SY_PULLUP] = cfg_pullup_sense;
    pins_raw[wws_pkg::SY_RAMP] = cfg_ramp_done;
    pins_raw[wws_pkg::SY_RST_PIN] = system_reset_n_in;
    pins_raw[wws_pkg::SY_WDO_PIN] = watchdog_fault_output_n_in;
  end

  wws_sync #(
    .W(wws_pkg::SYN_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(pins_raw),
    .reset_val(SYNC_INV),
    .sync_out(pins_s)
  );

  assign below_s = pins_s[wws_pkg::SY_BELOW];
  assign above_s = pins_s[wws_pkg::SY_ABOVE];
  assign mr_n_s = pins_s[wws_pkg::SY_MR_N]; // Pad pull-up keeps it high when open
  assign en_s = pins_s[wws_pkg::SY_EN];
  assign kick_s = pins_s[wws_pkg::SY_KICK];
  assign ramp_s = pins_s[wws_pkg::SY_RAMP];

  ////////////////////////////////////////////////////////////////////////////////
  // Supply hysteresis and reset sequencer

  wws_pkg::wws_rst_e rs_q, rs_d;
  logic supply_ok_q, supply_ok_d;
  logic [wws_pkg::CNT_W-1:0] hold_q, hold_d;
  logic rst_oe_q, rst_oe_d;
  logic cls_start;
  logic reset_cause;

  always_comb begin
    supply_ok_d = supply_ok_q;
    if (below_s) begin
      supply_ok_d = 1'b0;
    end else if (above_s) begin
      supply_ok_d = 1'b1;
    end
    reset_cause = below_s || !supply_ok_d || !mr_n_s;
    rs_d = rs_q;
    hold_d = hold_q;
    cls_start = 1'b0;
    unique case (rs_q)
      wws_pkg::RS_ASSERT: begin
        hold_d = '0;
        if (!reset_cause) begin
          rs_d = wws_pkg::RS_HOLD;
          cls_start = 1'b1;
        end
      end
      wws_pkg::RS_HOLD: begin
        hold_d = hold_q + 26'h0000001;
        if (reset_cause) begin
          rs_d = wws_pkg::RS_ASSERT;
        end else if (hold_q >= HOLD_C - 26'h0000001) begin
          rs_d = wws_pkg::RS_RELEASED;
        end
      end
      wws_pkg::RS_RELEASED: begin
        hold_d = '0;
        if (reset_cause) begin
          rs_d = wws_pkg::RS_ASSERT;
        end
      end
    endcase
    // Watchdog state plays no part here
    rst_oe_d = (rs_d != wws_pkg::RS_RELEASED);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rs_q <= wws_pkg::RS_ASSERT;
      supply_ok_q <= 1'b0;
      hold_q <= '0;
      rst_oe_q <= 1'b1;
    end else begin
      rs_q <= rs_d;
      supply_ok_q <= supply_ok_d;
      hold_q <= hold_d;
      rst_oe_q <= rst_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration pin classifier

  logic cls_charge;
  logic cls_busy;
  logic cls_valid;
  wws_pkg::wws_cfg_e cfg_mode;

  wws_cfg_detect #(
    .EVAL_CYC(EVAL_CYC)
  ) u_cfg (
    .core_clk(core_clk),
    .rst(rst),
    .start(cls_start),
    .pullup_sense(pins_s[wws_pkg::SY_PULLUP]),
    .ramp_done(ramp_s),
    .charge_req(cls_charge),
    .busy(cls_busy),
    .valid(cls_valid),
    .mode(cfg_mode)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Window watchdog

  wws_pkg::wws_wd_e wd_q, wd_d;
  logic [wws_pkg::CNT_W-1:0] wcnt_q, wcnt_d;
  logic [wws_pkg::CNT_W-1:0] ramp_meas_q, ramp_meas_d;
  logic kick_prev_q;
  logic kick_fall;
  logic wd_run;
  logic sw_wd_off_q, sw_wd_off_d;
  logic upper_hit;
  logic too_early;
  logic restart;
  logic [wws_pkg::CNT_W-1:0] low_c;
  logic wdo_oe_q, wdo_oe_d;
  logic charge_q, charge_d;
  localparam logic [wws_pkg::CNT_W-1:0] RAMP_GUARD_C = wws_pkg::RAMP_GUARD_CYC;

  assign kick_fall = kick_prev_q && !kick_s;
  assign wd_run = en_s && mr_n_s && (rs_q == wws_pkg::RS_RELEASED) && !sw_wd_off_q;

  always_comb begin
    unique case (cfg_mode)
      wws_pkg::CFG_PULLUP: low_c = LOW_PULL_C;
      wws_pkg::CFG_CAP: low_c = ramp_meas_q >> 1;
      default: low_c = LOW_FLOAT_C;
    endcase
    if (cfg_mode == wws_pkg::CFG_CAP) begin
      upper_hit = ramp_s && (wcnt_q >= RAMP_GUARD_C);
    end else if (cfg_mode == wws_pkg::CFG_PULLUP) begin
      upper_hit = (wcnt_q >= UP_PULL_C - 26'h0000001);
    end else begin
      upper_hit = (wcnt_q >= UP_FLOAT_C - 26'h0000001);
    end
    too_early = (wcnt_q < low_c);
  end

  always_comb begin
    wd_d = wd_q;
    wcnt_d = wcnt_q + 26'h0000001;
    ramp_meas_d = ramp_meas_q;
    restart = 1'b0;
    unique case (wd_q)
      wws_pkg::WD_OFF: begin
        wcnt_d = '0;
        wd_d = wws_pkg::WD_SETTLE;
      end
      wws_pkg::WD_SETTLE: begin
        // Kick edges are not looked at here
        if (wcnt_q >= wws_pkg::SETTLE_CYC - 26'h0000001 && cls_valid) begin
          wd_d = wws_pkg::WD_FIRST;
          wcnt_d = '0;
          restart = 1'b1;
        end
      end
      wws_pkg::WD_FIRST: begin
        if (kick_fall) begin
          wd_d = wws_pkg::WD_WINDOW;
          wcnt_d = '0;
          restart = 1'b1;
        end else if (upper_hit) begin
          wd_d = wws_pkg::WD_FAULT;
          wcnt_d = '0;
        end
      end
      wws_pkg::WD_WINDOW: begin
        if (cfg_mode == wws_pkg::CFG_CAP && upper_hit) begin
          ramp_meas_d = wcnt_q;
        end
        if (kick_fall && too_early) begin
          wd_d = wws_pkg::WD_FAULT;
          wcnt_d = '0;
        end else if (kick_fall) begin
          wcnt_d = '0;
          restart = 1'b1;
        end else if (upper_hit) begin
          wd_d = wws_pkg::WD_FAULT;
          wcnt_d = '0;
        end
      end
      wws_pkg::WD_FAULT: begin
        if (wcnt_q >= HOLD_C - 26'h0000001) begin
          wd_d = wws_pkg::WD_FIRST;
          wcnt_d = '0;
          restart = 1'b1;
        end
      end
    endcase
    if (!wd_run) begin
      wd_d = wws_pkg::WD_OFF;
      wcnt_d = '0;
    end
    wdo_oe_d = (wd_d == wws_pkg::WD_FAULT) && (rs_d == wws_pkg::RS_RELEASED);
    if (cls_busy) begin
      charge_d = cls_charge;
    end else begin
      // One idle cycle discharges the ramp at each window restart
      charge_d = (cfg_mode == wws_pkg::CFG_CAP) && !restart &&
        ((wd_d == wws_pkg::WD_FIRST) || (wd_d == wws_pkg::WD_WINDOW));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wd_q <= wws_pkg::WD_OFF;
      wcnt_q <= '0;
      ramp_meas_q <= '0;
      kick_prev_q <= 1'b0;
      wdo_oe_q <= 1'b0;
      charge_q <= 1'b0;
    end else begin
      wd_q <= wd_d;
      wcnt_q <= wcnt_d;
      ramp_meas_q <= ramp_meas_d;
      kick_prev_q <= kick_s;
      wdo_oe_q <= wdo_oe_d;
      charge_q <= charge_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port

  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status;

  always_comb begin
    status = '0;
    status[wws_pkg::ST_RST_BIT] = rst_oe_q;
    status[wws_pkg::ST_FAULT_BIT] = wdo_oe_q;
    status[wws_pkg::ST_MODE_LSB +: 2] = cfg_mode;
    status[wws_pkg::ST_VALID_BIT] = cls_valid;
    status[wws_pkg::ST_SUPV_BIT] = (wd_q == wws_pkg::WD_FIRST) || (wd_q == wws_pkg::WD_WINDOW);
    status[wws_pkg::ST_RST_PIN_BIT] = pins_s[wws_pkg::SY_RST_PIN];
    status[wws_pkg::ST_WDO_PIN_BIT] = pins_s[wws_pkg::SY_WDO_PIN];
    sw_wd_off_d = sw_wd_off_q;
    if (reg_wr && reg_addr == wws_pkg::REG_CTRL_ADDR) begin
      sw_wd_off_d = reg_wdata[wws_pkg::CTRL_WD_OFF_BIT];
    end
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        wws_pkg::REG_CTRL_ADDR: rdata_d[wws_pkg::CTRL_WD_OFF_BIT] = sw_wd_off_q;
        wws_pkg::REG_STATUS_ADDR: rdata_d = status;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw_wd_off_q <= wws_pkg::CTRL_RESET[wws_pkg::CTRL_WD_OFF_BIT];
      rdata_q <= '0;
    end else begin
      sw_wd_off_q <= sw_wd_off_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign system_reset_n_out = 1'b0;
  assign system_reset_n_oe = rst_oe_q;
  assign watchdog_fault_output_n_out = 1'b0;
  assign watchdog_fault_output_n_oe = wdo_oe_q;
  assign cfg_charge_en = charge_q;
  assign reg_rdata = rdata_q;

endmodule

// [test/wws_top_asserts.sv]
// Port checker for the window watchdog supervisor
module wws_chk #(
  parameter int HOLD_CYC = 50
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_below_falling,
  input wire logic supply_above_rising,
  input wire logic manual_reset_input_n,
  input wire logic watchdog_enable_select,
  input wire logic system_reset_n_oe,
  input wire logic watchdog_fault_output_n_oe
);
  logic [31:0] good_q, good_d, calm_q, calm_d, flt_q, flt_d;
  logic good, cause;
  assign good = supply_above_rising && !supply_below_falling && manual_reset_input_n;
  assign cause = supply_below_falling || !manual_reset_input_n;
  always_comb begin
    good_d = good ? good_q + 32'h1 : 32'h0;
    calm_d = cause ? 32'h0 : calm_q + 32'h1;
    flt_d = watchdog_fault_output_n_oe ? flt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      good_q <= 32'h0;
      calm_q <= 32'h0;
      flt_q <= 32'h0;
    end else begin
      good_q <= good_d;
      calm_q <= calm_d;
      flt_q <= flt_d;
    end
  end
  //////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_below_reset: assert property (supply_below_falling [*4] |-> system_reset_n_oe)
    else $error("reset not asserted on low supply");
  a_manual_reset: assert property (!manual_reset_input_n [*4] |-> system_reset_n_oe)
    else $error("reset not asserted on manual reset");
  a_manual_wd_off: assert property (!manual_reset_input_n [*4] |-> !watchdog_fault_output_n_oe)
    else $error("fault driven during manual reset");
  a_enable_off: assert property (!watchdog_enable_select [*5] |-> !watchdog_fault_output_n_oe)
    else $error("fault driven while disabled");
  a_reset_fault_off: assert property (system_reset_n_oe && $past(system_reset_n_oe)
    |-> !watchdog_fault_output_n_oe)
    else $error("fault driven during reset");
  a_release_hold: assert property ($fell(system_reset_n_oe) |-> good_q >= HOLD_CYC)
    else $error("reset released before hold time");
  a_release_bound: assert property (good_q == HOLD_CYC + 8 |-> !system_reset_n_oe)
    else $error("reset not released after hold time");
  a_fault_no_reset: assert property ($rose(system_reset_n_oe) |-> calm_q <= 4)
    else $error("reset asserted without a cause");
  a_idle_released: assert property (!system_reset_n_oe && calm_q > 5 |=> !system_reset_n_oe)
    else $error("reset asserted while supply good");
  a_fault_length: assert property ($fell(watchdog_fault_output_n_oe) && !system_reset_n_oe
    && watchdog_enable_select |-> flt_q >= HOLD_CYC - 1 && flt_q <= HOLD_CYC + 1)
    else $error("fault length differs from hold time");
  c_fault: cover property ($rose(watchdog_fault_output_n_oe));
  c_release: cover property ($fell(system_reset_n_oe));
  c_disable: cover property (!watchdog_enable_select [*5]);
endmodule

bind wws_top wws_chk #(.HOLD_CYC(HOLD_CYC)) u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .supply_below_falling(supply_below_falling),
  .supply_above_rising(supply_above_rising),
  .manual_reset_input_n(manual_reset_input_n),
  .watchdog_enable_select(watchdog_enable_select),
  .system_reset_n_oe(system_reset_n_oe),
  .watchdog_fault_output_n_oe(watchdog_fault_output_n_oe)
);

// [test/wws_host.sv]
// Host processor and pin network on the supervisor's far side
module wws_host #(
  parameter int RAMP_CYC = 40,
  parameter int CAP_RAMP_CYC = 200
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic kick_on,
  input wire logic [7:0] kick_gap,
  input wire logic pullup_mode,
  input wire logic cap_mode,
  input wire logic charge_en,
  input wire logic reset_oe,
  input wire logic fault_oe,
  output logic kick,
  output logic pullup_sense,
  output logic ramp_done,
  output logic reset_pin,
  output logic fault_pin
);
  logic [7:0] cnt;
  logic [15:0] ramp;
  // Open-drain wires with pull-ups
  assign reset_pin = !reset_oe;
  assign fault_pin = !fault_oe;
  assign pullup_sense = pullup_mode;
  // A capacitor charges far slower than an open pin
  assign ramp_done = ramp >= (cap_mode ? 16'(CAP_RAMP_CYC) : 16'(RAMP_CYC));
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      kick <= 1'b1;
      ramp <= 16'h0000;
    end else begin
      ramp <= charge_en ? ramp + 16'h0001 : 16'h0000;
      // Two-cycle low kick once per gap while out of reset
      if (kick_on && reset_pin && cnt >= kick_gap - 8'h01) begin
        kick <= 1'b0;
        cnt <= 8'h00;
      end else begin
        kick <= (cnt == 8'h00) ? kick : 1'b1;
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule

// [test/test_window_watchdog_supervisor.sv]
// Self-checking bench for the window watchdog supervisor
module test_window_watchdog_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 50;
  logic core_clk, rst, below, above, mr_n, en, kick, pu, ramp, chg;
  logic rst_pin, flt_pin, rst_oe, flt_oe, kick_on, pullup_mode, cap_mode, rst_out, flt_out;
  logic reg_wr, reg_rd;
  logic [7:0] gap;
  logic [wws_pkg::ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  wws_top #(.HOLD_CYC(HOLD), .LOW_FLOAT_CYC(20), .UP_FLOAT_CYC(40), .LOW_PULL_CYC(10),
    .UP_PULL_CYC(30), .EVAL_CYC(2100)) dut (
    .core_clk(core_clk), .rst(rst), .supply_below_falling(below),
    .supply_above_rising(above), .manual_reset_input_n(mr_n),
    .watchdog_enable_select(en), .watchdog_kick_input(kick), .cfg_pullup_sense(pu),
    .cfg_ramp_done(ramp), .cfg_charge_en(chg), .system_reset_n_in(rst_pin),
    .system_reset_n_out(rst_out), .system_reset_n_oe(rst_oe),
    .watchdog_fault_output_n_in(flt_pin), .watchdog_fault_output_n_out(flt_out),
    .watchdog_fault_output_n_oe(flt_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  wws_host host (
    .core_clk(core_clk), .rst(rst), .kick_on(kick_on), .kick_gap(gap),
    .pullup_mode(pullup_mode), .cap_mode(cap_mode), .charge_en(chg), .reset_oe(rst_oe),
    .fault_oe(flt_oe), .kick(kick), .pullup_sense(pu), .ramp_done(ramp), .reset_pin(rst_pin),
    .fault_pin(flt_pin));

  //////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pins(input logic er, input logic ef);
    @(negedge core_clk);
    chk("reset oe", 32'(er), 32'(rst_oe));
    chk("fault oe", 32'(ef), 32'(flt_oe));
    chk("pin drive level", 32'h00000000, 32'({rst_out, flt_out}));
  endtask
  task automatic wait_flt(input logic lvl, input int max);
    for (int i = 0; i < max && flt_oe !== lvl; i++) @(negedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(what, exp, reg_rdata);
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  //////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    below = 1'b1;
    above = 1'b0;
    mr_n = 1'b1;
    en = 1'b1;
    kick_on = 1'b1;
    gap = 8'h14;
    pullup_mode = 1'b1;
    cap_mode = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tick(4);
    rst <= 1'b0;
    tick(10);
    pins(1'b1, 1'b0);
    tick(1);
    below <= 1'b0;
    tick(HOLD + 10);
    pins(1'b1, 1'b0);
    tick(1);
    above <= 1'b1;
    tick(HOLD - 5);
    pins(1'b1, 1'b0);
    tick(15);
    pins(1'b0, 1'b0);
    tick(1);
    above <= 1'b0;
    tick(20);
    pins(1'b0, 1'b0);
    done("supply");
    tick(1);
    below <= 1'b1;
    tick(4);
    pins(1'b1, 1'b0);
    tick(1);
    below <= 1'b0;
    above <= 1'b1;
    tick(HOLD + 15);
    pins(1'b0, 1'b0);
    tick(3200);
    pins(1'b0, 1'b0);
    rd("status", wws_pkg::REG_STATUS_ADDR, 32'h000000F4);
    tick(300);
    pins(1'b0, 1'b0);
    done("window");
    tick(1);
    gap <= 8'h05;
    wait_flt(1'b1, 60);
    pins(1'b0, 1'b1);
    tick(1);
    gap <= 8'h14;
    tick(HOLD - 8);
    pins(1'b0, 1'b1);
    wait_flt(1'b0, 20);
    tick(200);
    pins(1'b0, 1'b0);
    tick(1);
    kick_on <= 1'b0;
    wait_flt(1'b1, 60);
    pins(1'b0, 1'b1);
    wait_flt(1'b0, HOLD + 10);
    tick(1);
    kick_on <= 1'b1;
    tick(100);
    pins(1'b0, 1'b0);
    done("faults");
    tick(1);
    en <= 1'b0;
    tick(100);
    pins(1'b0, 1'b0);
    tick(1);
    en <= 1'b1;
    kick_on <= 1'b0;
    tick(2950);
    pins(1'b0, 1'b0);
    tick(1);
    kick_on <= 1'b1;
    tick(400);
    pins(1'b0, 1'b0);
    done("enable");
    rd("ctrl", wws_pkg::REG_CTRL_ADDR, 32'h00000000);
    wr(wws_pkg::REG_CTRL_ADDR, 32'h00000001);
    rd("ctrl", wws_pkg::REG_CTRL_ADDR, 32'h00000001);
    tick(1);
    kick_on <= 1'b0;
    tick(200);
    pins(1'b0, 1'b0);
    rd("unmapped", 4'h8, 32'h00000000);
    wr(4'h8, 32'hFFFFFFFF);
    rd("ctrl", wws_pkg::REG_CTRL_ADDR, 32'h00000001);
    wr(wws_pkg::REG_CTRL_ADDR, 32'h00000000);
    tick(2950);
    kick_on <= 1'b1;
    tick(400);
    pins(1'b0, 1'b0);
    done("registers");
    tick(1);
    mr_n <= 1'b0;
    tick(4);
    pins(1'b1, 1'b0);
    tick(100);
    mr_n <= 1'b1;
    tick(HOLD - 5);
    pins(1'b1, 1'b0);
    tick(15);
    pins(1'b0, 1'b0);
    tick(3400);
    pins(1'b0, 1'b0);
    rd("status", wws_pkg::REG_STATUS_ADDR, 32'h000000F4);
    done("manual");
    tick(1);
    pullup_mode <= 1'b0;
    gap <= 8'h1E;
    mr_n <= 1'b0;
    tick(20);
    mr_n <= 1'b1;
    tick(HOLD + 3500);
    rd("status", wws_pkg::REG_STATUS_ADDR, 32'h000000F0);
    tick(300);
    pins(1'b0, 1'b0);
    done("float");
    tick(1);
    cap_mode <= 1'b1;
    mr_n <= 1'b0;
    tick(20);
    mr_n <= 1'b1;
    tick(HOLD + 3500);
    rd("status", wws_pkg::REG_STATUS_ADDR, 32'h000000F8);
    tick(300);
    pins(1'b0, 1'b0);
    tick(1);
    kick_on <= 1'b0;
    wait_flt(1'b1, 300);
    pins(1'b0, 1'b1);
    wait_flt(1'b0, HOLD + 10);
    tick(1);
    kick_on <= 1'b1;
    wait_flt(1'b1, 200);
    pins(1'b0, 1'b1);
    wait_flt(1'b0, HOLD + 10);
    tick(1);
    gap <= 8'h96;
    tick(600);
    pins(1'b0, 1'b0);
    done("capacitor");
    summarize();
  end
endmodule
